// ### rtl/iot_exec.sv
/*
  Execution unit for the port input/output and data transfer instructions
  of a 4-bit core: accumulator, carry, 32 general registers, port latches,
  page register and the program memory address.
  Assumes the fetch logic presents both words of an instruction with a
  one-cycle instr_valid, and that program memory answers rom_addr
  combinationally on rom_data within the same cycle.
*/
`timescale 1ns/1ps
module iot_exec (
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic instr_valid,
  input wire logic [iot_pkg::WORD_W-1:0] instr_word,
  input wire logic [iot_pkg::WORD_W-1:0] instr_word2,
  input wire logic [iot_pkg::WORD_W-1:0] rom_data,
  input wire logic page_load,
  input wire logic [iot_pkg::PAGE_W-1:0] page_value,
  input wire logic [1:0][3:0][3:0] port_pins_in,
  output logic [1:0][3:0][3:0] port_latch,
  output logic [iot_pkg::DATA_W-1:0] accumulator,
  output logic carry_flag,
  output logic [iot_pkg::WORD_W-1:0] rom_addr,
  output logic [iot_pkg::PAGE_W-1:0] rom_page_select_control,
  output logic [1:0] rom_extra_bits,
  output logic exec_done,
  output logic instr_undefined
);
  import iot_pkg::*;

  logic [1:0][3:0][3:0] port_sync;
  logic [1:0][15:0][3:0] regs;
  iot_op_type op;
  logic [2:0] slot_code;
  logic port_group;
  logic [1:0] slot;
  logic [3:0] port_val;
  logic [3:0] rom_nibble;
  logic [3:0] next_acc;
  logic next_carry;
  logic acc_wr;
  logic lo_wr;
  logic hi_wr;
  logic [3:0] wr_idx;
  logic [3:0] lo_data;
  logic [3:0] hi_data;
  logic next_undef;
  logic [7:0] next_pair0;
  logic [PAGE_W-1:0] next_page;

  iot_sync #(.WIDTH(32)) u_pin_sync (
    .sys_clk(sys_clk),
    .rst(rst),
    .pins(port_pins_in),
    .synced(port_sync)
  );

  // port selection fields and the value of the addressed port
  assign port_group = instr_word[GROUP_BIT]; // RULE17
  assign slot_code = iot_port_slot(instr_word[2:0]); // RULE17
  assign slot = slot_code[1:0];
  assign port_val = port_sync[port_group][slot];

  // nibble taken from the addressed rom word; bits 9 and 8 never reach it
  assign rom_nibble = (op == IOT_OP_ROM_HIGH) ? rom_data[7:4] : rom_data[3:0]; // RULE9 RULE10

  // decode; port codes other than 0, 1, 3, 4 fall to none
  always_comb begin
    op = IOT_OP_NONE;
    next_undef = 1'b0;
    if (instr_word == OPC_ROM_HIGH) begin
      op = IOT_OP_ROM_HIGH;
    end else if (instr_word == OPC_ROM_LOW) begin
      op = IOT_OP_ROM_LOW;
    end else if (instr_word == OPC_ACC_IMM) begin
      op = IOT_OP_ACC_IMM;
    end else if (instr_word[9:3] == OPC_PORT_IMM) begin
      op = IOT_OP_PORT_IMM;
    end else if (instr_word[9:4] == OPC_PAIR_ROM) begin
      op = IOT_OP_PAIR_ROM;
    end else if (instr_word[9:4] == OPC_PAIR_IMM) begin
      op = IOT_OP_PAIR_IMM;
    end else if (instr_word[4:3] == OPC_PORT_TAG) begin
      unique case (instr_word[9:6])
        OPC_TOP_IN: op = IOT_OP_IN;
        OPC_TOP_OUT: op = IOT_OP_OUT;
        OPC_TOP_AND: op = IOT_OP_AND;
        OPC_TOP_OR: op = IOT_OP_OR;
        OPC_TOP_XOR: op = IOT_OP_XOR;
        default: op = IOT_OP_NONE;
      endcase
    end else if (instr_word[4] == 1'b0 && instr_word[9:6] == OPC_TOP_IN) begin
      op = IOT_OP_REG_TO_ACC;
    end else if (instr_word[4] == 1'b0 && instr_word[9:6] == OPC_TOP_OUT) begin
      op = IOT_OP_ACC_TO_REG;
    end
    // a port opcode with an undefined port number does nothing
    if (!slot_code[2] && op inside {IOT_OP_IN, IOT_OP_OUT, IOT_OP_AND, IOT_OP_OR,
                                     IOT_OP_XOR, IOT_OP_PORT_IMM}) begin // RULE2
      op = IOT_OP_NONE;
    end
    // pair 0 cannot take a rom word: it is the pointer being used
    if (op == IOT_OP_PAIR_ROM && instr_word[3:0] == 4'h0) begin // RULE15
      op = IOT_OP_NONE;
    end
    if (op == IOT_OP_NONE) begin
      next_undef = instr_valid;
    end
  end

  // accumulator and carry results
  always_comb begin
    acc_wr = 1'b1;
    next_acc = accumulator;
    next_carry = carry_flag;
    unique case (op)
      IOT_OP_IN: begin
        next_acc = port_val; // RULE1
        next_carry = 1'b0; // RULE1
      end
      IOT_OP_AND: begin
        next_acc = accumulator & port_val; // RULE4
        next_carry = accumulator[3] & port_val[3]; // RULE4
      end
      IOT_OP_OR: begin
        next_acc = accumulator | port_val; // RULE5
        next_carry = 1'b0; // RULE5
      end
      IOT_OP_XOR: begin
        next_acc = accumulator ^ port_val; // RULE6
        next_carry = accumulator[3] & port_val[3]; // RULE6
      end
      IOT_OP_REG_TO_ACC: begin
        next_acc = regs[instr_word[BANK_BIT]][instr_word[3:0]]; // RULE8 RULE18
        next_carry = 1'b0; // RULE8
      end
      IOT_OP_ROM_HIGH, IOT_OP_ROM_LOW: begin
        next_acc = rom_nibble; // RULE9 RULE10
        next_carry = 1'b0; // RULE9 RULE10
      end
      IOT_OP_ACC_IMM: begin
        next_acc = instr_word2[3:0]; // RULE12
        next_carry = 1'b0; // RULE12
      end
      default: acc_wr = 1'b0;
    endcase
  end

  // register writes: up to one bank 0 and one bank 1 entry, same index
  always_comb begin
    lo_wr = 1'b0;
    hi_wr = 1'b0;
    wr_idx = instr_word[3:0]; // RULE18
    lo_data = accumulator;
    hi_data = accumulator;
    unique case (op)
      IOT_OP_ACC_TO_REG: begin
        lo_wr = ~instr_word[BANK_BIT]; // RULE13
        hi_wr = instr_word[BANK_BIT]; // RULE13
      end
      IOT_OP_PAIR_IMM: begin
        lo_wr = 1'b1;
        hi_wr = 1'b1;
        lo_data = instr_word2[3:0]; // RULE14
        hi_data = instr_word2[7:4]; // RULE14
      end
      IOT_OP_PAIR_ROM: begin
        lo_wr = 1'b1;
        hi_wr = 1'b1;
        lo_data = rom_data[3:0]; // RULE19
        hi_data = rom_data[7:4]; // RULE19
      end
      default: begin
        lo_wr = 1'b0;
        hi_wr = 1'b0;
      end
    endcase
  end

  // accumulator and carry
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      accumulator <= RESET_NIBBLE;
      carry_flag <= RESET_CARRY;
    end else if (instr_valid && acc_wr) begin
      accumulator <= next_acc;
      carry_flag <= next_carry;
    end
  end

  // general registers, kept in flops
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      regs <= '0;
    end else if (instr_valid) begin
      if (lo_wr) begin
        regs[0][wr_idx] <= lo_data;
      end
      if (hi_wr) begin
        regs[1][wr_idx] <= hi_data;
      end
    end
  end

  // port output latches hold until the next write
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      port_latch <= '0;
    end else if (instr_valid && op == IOT_OP_OUT) begin
      port_latch[port_group][slot] <= accumulator; // RULE3
    end else if (instr_valid && op == IOT_OP_PORT_IMM) begin
      port_latch[1][slot] <= instr_word2[7:4]; // RULE7
      port_latch[0][slot] <= instr_word2[3:0]; // RULE7
    end
  end

  // bits 9 and 8 of a rom word moved into a pair
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      rom_extra_bits <= 2'h0;
    end else if (instr_valid && op == IOT_OP_PAIR_ROM) begin
      rom_extra_bits <= rom_data[9:8]; // RULE19
    end
  end

  // page register; only page 0 is populated, so software keeps it at 0
  assign next_page = page_load ? page_value : rom_page_select_control; // RULE16
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      rom_page_select_control <= RESET_PAGE;
    end else begin
      rom_page_select_control <= next_page;
    end
  end

  // pointer pair after this cycle's writes, so rom_addr is never stale
  always_comb begin
    next_pair0 = {regs[1][0], regs[0][0]};
    if (instr_valid && wr_idx == 4'h0) begin
      if (hi_wr) begin
        next_pair0[7:4] = hi_data;
      end
      if (lo_wr) begin
        next_pair0[3:0] = lo_data;
      end
    end
  end

  // rom address: page above the pointer pair, bank 1 high nibble
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      rom_addr <= '0;
    end else begin
      rom_addr <= {next_page, next_pair0}; // RULE11
    end
  end

  // completion and undefined-code pulses
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      exec_done <= 1'b0;
      instr_undefined <= 1'b0;
    end else begin
      exec_done <= instr_valid; // RULE1
      instr_undefined <= next_undef; // RULE2
    end
  end

  // checks
  chk_in_load: assert property (@(posedge sys_clk) disable iff (rst) // RULE1
    instr_valid && op == IOT_OP_IN |=> accumulator == $past(port_val) && !carry_flag)
    else $error("port input did not load accumulator");

  chk_bad_port: assert property (@(posedge sys_clk) disable iff (rst) // RULE2
    instr_valid && instr_word[9:6] == OPC_TOP_OUT && instr_word[4:3] == OPC_PORT_TAG
    && !slot_code[2] |=> $stable(port_latch) && instr_undefined)
    else $error("undefined port number changed a latch");

  chk_out_hold: assert property (@(posedge sys_clk) disable iff (rst) // RULE3
    instr_valid && op == IOT_OP_OUT |=> port_latch[$past(port_group)][$past(slot)] == $past(accumulator))
    else $error("port output not latched");

  chk_and_carry: assert property (@(posedge sys_clk) disable iff (rst) // RULE4
    instr_valid && op == IOT_OP_AND |=> carry_flag == ($past(accumulator[3]) & $past(port_val[3])))
    else $error("port and carry wrong");

  chk_or_result: assert property (@(posedge sys_clk) disable iff (rst) // RULE5
    instr_valid && op == IOT_OP_OR |=> accumulator == ($past(accumulator) | $past(port_val)) && !carry_flag)
    else $error("port or result wrong");

  chk_xor_result: assert property (@(posedge sys_clk) disable iff (rst) // RULE6
    instr_valid && op == IOT_OP_XOR |=> accumulator == ($past(accumulator) ^ $past(port_val)))
    else $error("port xor result wrong");

  chk_imm_pair: assert property (@(posedge sys_clk) disable iff (rst) // RULE7
    instr_valid && op == IOT_OP_PORT_IMM |=>
    {port_latch[1][$past(slot)], port_latch[0][$past(slot)]} == $past(instr_word2[7:0]))
    else $error("immediate byte not split over port pair");

  chk_rom_high: assert property (@(posedge sys_clk) disable iff (rst) // RULE9
    instr_valid && op == IOT_OP_ROM_HIGH |=> accumulator == $past(rom_data[7:4]) && !carry_flag)
    else $error("high nibble fetch wrong");

  chk_rom_addr: assert property (@(posedge sys_clk) disable iff (rst) // RULE11
    instr_valid && op == IOT_OP_PAIR_IMM && instr_word[3:0] == 4'h0
    |=> rom_addr[7:0] == $past(instr_word2[7:0]))
    else $error("rom pointer not updated from pair 0");

  // checked at the very next edge, so a following instruction cannot mask a missed write
  chk_reg_move: assert property (@(posedge sys_clk) disable iff (rst) // RULE13
    instr_valid && op == IOT_OP_ACC_TO_REG |=> $stable(accumulator) && $stable(carry_flag)
    && $stable(port_latch) && regs[$past(instr_word[BANK_BIT])][$past(instr_word[3:0])] == $past(accumulator))
    else $error("register move changed other state or missed");

  chk_pair_rom: assert property (@(posedge sys_clk) disable iff (rst) // RULE19
    instr_valid && op == IOT_OP_PAIR_ROM |=> rom_extra_bits == $past(rom_data[9:8]))
    else $error("rom word upper bits not kept");

  chk_done_pulse: assert property (@(posedge sys_clk) disable iff (rst) // RULE1
    instr_valid |=> exec_done)
    else $error("instruction did not complete in one cycle");

  chk_and_result: assert property (@(posedge sys_clk) disable iff (rst) // RULE4
    instr_valid && op == IOT_OP_AND |=> accumulator == ($past(accumulator) & $past(port_val)))
    else $error("port and result wrong");

  chk_xor_carry: assert property (@(posedge sys_clk) disable iff (rst) // RULE6
    instr_valid && op == IOT_OP_XOR |=> carry_flag == ($past(accumulator[3]) & $past(port_val[3])))
    else $error("port xor carry wrong");

  chk_reg_to_acc: assert property (@(posedge sys_clk) disable iff (rst) // RULE8
    instr_valid && op == IOT_OP_REG_TO_ACC
    |=> accumulator == $past(regs[instr_word[BANK_BIT]][instr_word[3:0]]) && !carry_flag)
    else $error("register to accumulator move wrong");

  chk_rom_low: assert property (@(posedge sys_clk) disable iff (rst) // RULE10
    instr_valid && op == IOT_OP_ROM_LOW |=> accumulator == $past(rom_data[3:0]) && !carry_flag)
    else $error("low nibble fetch wrong");

  chk_acc_imm: assert property (@(posedge sys_clk) disable iff (rst) // RULE12
    instr_valid && op == IOT_OP_ACC_IMM |=> accumulator == $past(instr_word2[3:0]) && !carry_flag)
    else $error("immediate nibble not loaded");

  // both halves of the pair land at the same index
  chk_pair_imm: assert property (@(posedge sys_clk) disable iff (rst) // RULE14
    instr_valid && op == IOT_OP_PAIR_IMM
    |=> regs[1][$past(instr_word[3:0])] == $past(instr_word2[7:4])
    && regs[0][$past(instr_word[3:0])] == $past(instr_word2[3:0]))
    else $error("immediate byte not split over register pair");

  // pair 0 is the pointer, so a rom word must never land there
  chk_pair0_refused: assert property (@(posedge sys_clk) disable iff (rst) // RULE15
    instr_valid && instr_word[9:4] == OPC_PAIR_ROM && instr_word[3:0] == 4'h0
    |=> $stable(regs) && instr_undefined)
    else $error("rom word moved into pointer pair");
endmodule : iot_exec

// ### rtl/iot_pkg.sv
/*
  Constants, opcode patterns and helper functions for the port and data
  transfer execution unit of a 4-bit core.
  Assumes one 10 MHz core clock and an active-high asynchronous reset.
*/
// Overview of operation
// [RULE1] port input loads accumulator from port, clears carry, one cycle
// [RULE2] only port numbers 0, 1, 3, 4 in group 0 or 1 exist
// [RULE3] port output latches accumulator into port, held until rewritten
// [RULE4] port and: accumulator anded with port, carry = a3 and port bit 3
// [RULE5] port or: accumulator ored with port, carry cleared
// [RULE6] port xor: accumulator xored with port, carry = a3 and port bit 3
// [RULE7] immediate byte to port pair: high nibble group 1, low nibble group 0
// [RULE8] register to accumulator from any of 32 registers, carry cleared
// [RULE9] high nibble fetch loads rom bits 7-4, ignores bit 9, clears carry
// [RULE10] low nibble fetch loads rom bits 3-0, ignores bit 8, clears carry
// [RULE11] rom address is page bits above pair 0 (bank 1 high nibble)
// [RULE12] immediate nibble from second word low bits loads accumulator, carry cleared
// [RULE13] accumulator to register writes one register, nothing else changes
// [RULE14] immediate byte to pair: bank 1 upper nibble, bank 0 lower nibble
// [RULE15] rom word to pair 1 to F, addressed by page and pair 0
// [RULE16] program memory spans 000H to 3FFH, only page 0 in use
// [RULE17] group bit picks port group, low three bits pick port number
// [RULE18] bank bit picks register bank, low four bits pick index
// [RULE19] pair gets rom bits 7-0; bits 9 and 8 go to extra storage
package iot_pkg;

  localparam int DATA_W = 4;
  localparam int WORD_W = 10;
  localparam int PAGE_W = 2;
  localparam int PAIR_W = 8;

  // values after reset
  localparam logic [3:0] RESET_NIBBLE = 4'h0;
  localparam logic RESET_CARRY = 1'b0;
  localparam logic [1:0] RESET_PAGE = 2'h0;

  // field positions in the first instruction word
  localparam int GROUP_BIT = 5;
  localparam int BANK_BIT = 5;

  // opcode patterns
  localparam logic [3:0] OPC_TOP_IN = 4'hf;
  localparam logic [3:0] OPC_TOP_OUT = 4'h2;
  localparam logic [3:0] OPC_TOP_AND = 4'hd;
  localparam logic [3:0] OPC_TOP_OR = 4'he;
  localparam logic [3:0] OPC_TOP_XOR = 4'ha;
  localparam logic [1:0] OPC_PORT_TAG = 2'h3;
  localparam logic [9:0] OPC_ROM_HIGH = 10'h3d0;
  localparam logic [9:0] OPC_ROM_LOW = 10'h3f0;
  localparam logic [9:0] OPC_ACC_IMM = 10'h3f1;
  localparam logic [6:0] OPC_PORT_IMM = 7'h1b;
  localparam logic [5:0] OPC_PAIR_ROM = 6'h0e;
  localparam logic [5:0] OPC_PAIR_IMM = 6'h0c;

  typedef enum logic [3:0] {
    IOT_OP_NONE, IOT_OP_IN, IOT_OP_OUT, IOT_OP_AND, IOT_OP_OR, IOT_OP_XOR,
    IOT_OP_PORT_IMM, IOT_OP_REG_TO_ACC, IOT_OP_ROM_HIGH, IOT_OP_ROM_LOW,
    IOT_OP_ACC_IMM, IOT_OP_ACC_TO_REG, IOT_OP_PAIR_IMM, IOT_OP_PAIR_ROM
  } iot_op_type;

  // port number to storage slot; bit 2 of the result marks a legal number
  function automatic logic [2:0] iot_port_slot(input logic [2:0] num);
    unique case (num)
      3'h0: iot_port_slot = 3'h4;
      3'h1: iot_port_slot = 3'h5;
      3'h3: iot_port_slot = 3'h6;
      3'h4: iot_port_slot = 3'h7;
      default: iot_port_slot = 3'h0;
    endcase
  endfunction : iot_port_slot

endpackage : iot_pkg

// ### rtl/iot_sync.sv
/*
  Two-stage synchroniser for the port input pins.
  Assumes the pins change with no relation to sys_clk.
*/
`timescale 1ns/1ps
module iot_sync #(
  parameter int WIDTH = 32
) (
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic [WIDTH-1:0] pins,
  output logic [WIDTH-1:0] synced
);
  logic [WIDTH-1:0] stage1;

  // first stage is read by the second stage only
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      stage1 <= '0;
      synced <= '0;
    end else begin
      stage1 <= pins;
      synced <= stage1;
    end
  end
endmodule : iot_sync

// ### bench/io_and_transfer_instr_exec_bench.sv
/*
  Self-checking bench for the port and data transfer execution unit.
  Assumes rtl/ is compiled first; the bench plays fetch logic, program
  memory and the port pins, all driven at the rising edge.
*/
`timescale 1ns/1ps
module io_and_transfer_instr_exec_bench;
  import iot_pkg::*;
  typedef struct packed {
    logic [9:0] w1;
    logic [9:0] w2;
    logic [3:0] acc;
    logic cy;
  } iot_row_type;
  localparam int N_ROWS = 27;
  // first word, second word, accumulator and carry expected after it
  localparam iot_row_type ROWS [N_ROWS] = '{
    '{10'h3f1, 10'h00c, 4'hc, 1'b0},
    '{10'h358, 10'h000, 4'h8, 1'b1},
    '{10'h3b9, 10'h000, 4'hd, 1'b0},
    '{10'h2bb, 10'h000, 4'h2, 1'b1},
    '{10'h3dc, 10'h000, 4'h3, 1'b0},
    '{10'h3f8, 10'h000, 4'ha, 1'b0},
    '{10'h0a5, 10'h000, 4'ha, 1'b0},
    '{10'h3f1, 10'h003, 4'h3, 1'b0},
    '{10'h3e5, 10'h000, 4'ha, 1'b0},
    '{10'h0c0, 10'h037, 4'ha, 1'b0},
    '{10'h3e0, 10'h000, 4'h3, 1'b0},
    '{10'h3c0, 10'h000, 4'h7, 1'b0},
    '{10'h3fc, 10'h000, 4'h8, 1'b0},
    '{10'h2bb, 10'h000, 4'h7, 1'b1},
    '{10'h3d0, 10'h000, 4'ha, 1'b0},
    '{10'h3f0, 10'h000, 4'h8, 1'b0},
    '{10'h0e3, 10'h000, 4'h8, 1'b0},
    '{10'h3e3, 10'h000, 4'ha, 1'b0},
    '{10'h3c3, 10'h000, 4'h8, 1'b0},
    '{10'h3f1, 10'h006, 4'h6, 1'b0},
    '{10'h089, 10'h000, 4'h6, 1'b0},
    '{10'h3f1, 10'h00b, 4'hb, 1'b0},
    '{10'h3c9, 10'h000, 4'h6, 1'b0},
    '{10'h3f1, 10'h00d, 4'hd, 1'b0},
    '{10'h299, 10'h000, 4'hb, 1'b0},
    '{10'h359, 10'h000, 4'h2, 1'b0},
    '{10'h3f1, 10'h008, 4'h8, 1'b0}
  };
  logic sys_clk = 1'b0;
  logic rst = 1'b1;
  logic instr_valid = 1'b0;
  logic [WORD_W-1:0] instr_word = 10'h000;
  logic [WORD_W-1:0] instr_word2 = 10'h000;
  logic [WORD_W-1:0] rom_data;
  logic page_load = 1'b0;
  logic [PAGE_W-1:0] page_value = 2'h0;
  // pins never move, so the synchroniser delay never matters
  logic [1:0][3:0][3:0] port_pins_in = 32'h8f5a3c69;
  logic [1:0][3:0][3:0] port_latch;
  logic [DATA_W-1:0] accumulator;
  logic carry_flag;
  logic [WORD_W-1:0] rom_addr;
  logic [PAGE_W-1:0] rom_page_select_control;
  logic [1:0] rom_extra_bits;
  logic exec_done;
  logic instr_undefined;
  int n_fail = 0;
  int tests_run = 0;
  int cycles = 0;
  logic [2:0] bad [4] = '{3'h2, 3'h5, 3'h6, 3'h7};

  always #50 sys_clk = ~sys_clk;

  // program memory model; rotation makes page bits reach rom bits 7 and 6, the high nibble
  assign rom_data = {rom_addr[1:0], rom_addr[9:2]} ^ 10'h2a5;

  iot_exec u_iot_exec (
    .sys_clk(sys_clk),
    .rst(rst),
    .instr_valid(instr_valid),
    .instr_word(instr_word),
    .instr_word2(instr_word2),
    .rom_data(rom_data),
    .page_load(page_load),
    .page_value(page_value),
    .port_pins_in(port_pins_in),
    .port_latch(port_latch),
    .accumulator(accumulator),
    .carry_flag(carry_flag),
    .rom_addr(rom_addr),
    .rom_page_select_control(rom_page_select_control),
    .rom_extra_bits(rom_extra_bits),
    .exec_done(exec_done),
    .instr_undefined(instr_undefined)
  );

  task automatic close_out();
    $display("comparisons %0d mismatches %0d", tests_run, n_fail);
    if (n_fail == 0 && tests_run > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask : close_out

  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    tests_run++;
    if (got !== exp) begin
      n_fail++;
      $display("[FAIL] %s expected %h seen %h", what, exp, got);
    end
  endtask : chk

  // one instruction, then a quiet cycle; results sampled after the edge settles
  task automatic issue(input logic [9:0] w1, input logic [9:0] w2);
    @(posedge sys_clk);
    instr_valid <= 1'b1;
    instr_word <= w1;
    instr_word2 <= w2;
    @(posedge sys_clk);
    instr_valid <= 1'b0;
    #1;
    chk("exec_done", 32'h1, exec_done);
  endtask : issue

  // hang guard: whole run needs under a hundred cycles
  always @(posedge sys_clk) begin
    cycles <= cycles + 1;
    if (cycles == 3000) begin
      n_fail++;
      $display("[FAIL] run length expected below 3000 seen 3000");
      close_out();
    end
  end

  initial begin
    repeat (3) @(posedge sys_clk);
    rst <= 1'b0;
    #1;
    chk("accumulator after reset", 32'h0, accumulator);
    chk("carry after reset", 32'h0, carry_flag);
    $display("test reset release done");
    // table of ordinary instructions, state carried from row to row
    for (int i = 0; i < N_ROWS; i++) begin
      issue(ROWS[i].w1, ROWS[i].w2);
      chk("accumulator", {28'h0000000, ROWS[i].acc}, accumulator);
      chk("carry_flag", {31'h00000000, ROWS[i].cy}, carry_flag);
      chk("instr_undefined", 32'h0, instr_undefined);
    end
    chk("rom_extra_bits", 32'h1, rom_extra_bits);
    $display("test instruction table done");
    // back-to-back: port output then immediate byte to a port pair
    @(posedge sys_clk);
    instr_valid <= 1'b1;
    instr_word <= 10'h0b9;
    @(posedge sys_clk);
    instr_word <= 10'h0db;
    instr_word2 <= 10'h0c6;
    @(posedge sys_clk);
    instr_valid <= 1'b0;
    #1;
    chk("port_latch", 32'h0c800600, port_latch);
    $display("test port output done");
    // illegal port numbers in both directions leave everything alone
    for (int i = 0; i < 4; i++) begin
      issue({OPC_TOP_IN, 1'b0, OPC_PORT_TAG, bad[i]}, 10'h000);
      chk("undefined in", 32'h1, instr_undefined);
      chk("accumulator kept", 32'h8, accumulator);
      issue({OPC_TOP_OUT, 1'b1, OPC_PORT_TAG, bad[i]}, 10'h000);
      chk("undefined out", 32'h1, instr_undefined);
      chk("port_latch kept", 32'h0c800600, port_latch);
    end
    issue(10'h0e0, 10'h000);
    chk("undefined pair 0", 32'h1, instr_undefined);
    @(posedge sys_clk);
    #1;
    chk("rom_addr kept", 32'h037, rom_addr);
    $display("test undefined codes done");
    // page bits form the top of the table address
    @(posedge sys_clk);
    page_load <= 1'b1;
    page_value <= 2'h1;
    @(posedge sys_clk);
    page_load <= 1'b0;
    page_value <= 2'h0;
    @(posedge sys_clk);
    #1;
    chk("page register", 32'h1, rom_page_select_control);
    chk("rom_addr page 1", 32'h137, rom_addr);
    issue(OPC_ROM_HIGH, 10'h000);
    chk("high nibble page 1", 32'he, accumulator);
    @(posedge sys_clk);
    page_load <= 1'b1;
    @(posedge sys_clk);
    page_load <= 1'b0;
    @(posedge sys_clk);
    #1;
    chk("rom_addr page 0", 32'h037, rom_addr);
    $display("test page select done");
    // reset in mid-run clears all visible state
    @(posedge sys_clk);
    rst <= 1'b1;
    @(posedge sys_clk);
    #1;
    chk("accumulator in reset", 32'h0, accumulator);
    chk("port_latch in reset", 32'h0, port_latch);
    chk("rom_extra_bits in reset", 32'h0, rom_extra_bits);
    @(posedge sys_clk);
    rst <= 1'b0;
    issue(OPC_ACC_IMM, 10'h005);
    chk("accumulator after reset", 32'h5, accumulator);
    $display("test mid-run reset done");
    close_out();
  end
endmodule : io_and_transfer_instr_exec_bench
